// [dv/cpu_partner.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// processor behind the reset: drives the memory enable, counts resets
// ---------------------------------------------------------------
module cpu_partner (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic mem_req,
	output logic      mem_enable_in_n,
	output int        reset_count
);
	logic prev_q;

	initial begin
		mem_enable_in_n = 1'h1;
		reset_count = 0;
		prev_q = 1'h1;
	end

	always @(negedge sys_clk) begin
		// a processor held in reset drives junk, so the gate must block it
		if (rst_n === 1'h0)
			mem_enable_in_n <= ~mem_enable_in_n;
		else
			mem_enable_in_n <= ~mem_req;
		if (prev_q === 1'h1 && rst_n === 1'h0)
			reset_count <= reset_count + 1;
		prev_q <= rst_n;
	end
endmodule

// [dv/supervisor_reset_sequencer_test.sv]
`timescale 1ns/1ps
module supervisor_reset_sequencer_test;
	import sup_pkg::*;
	localparam int unsigned HT = 1400;
	localparam int          TK = 8;
	localparam int          H  = HT * TK;

	logic                  sys_clk = 1'h0;
	logic                  reset = 1'h1;
	logic                  manual_reset_in_n = 1'h1;
	logic [NUM_BUTTON-1:0] button_n = 2'h3;
	logic [NUM_BUTTON-1:0] button_need = 2'h3;
	logic                  long_press_mode = 1'h0;
	logic [NUM_SUPPLY-1:0] supply_low_detect = 5'h00;
	logic                  main_supply_fail = 1'h1;
	logic                  seal_request = 1'h0;
	logic                  watchdog_fault = 1'h0;
	logic                  watchdog_irq_mode = 1'h0;
	logic                  mem_req = 1'h0;
	logic                  mem_enable_in_n;
	logic                  sys_reset_out;
	logic                  mem_enable_out_n;
	logic                  backup_select;
	logic                  watchdog_irq;
	int                    resets;
	int                    num_errors = 0;
	int                    n_compared = 0;

	always #4 sys_clk = ~sys_clk;

	supervisor_reset_sequencer #(
		.HOLD_TICKS      (HT),
		.DEB_TICKS       (4),
		.HOLD_PRESS_TICKS(8),
		.TICK_LEN        (TK),
		.RESET_ACT_HIGH  (1'b0)
	) dut_u (
		.sys_clk          (sys_clk),
		.reset            (reset),
		.manual_reset_in_n(manual_reset_in_n),
		.button_n         (button_n),
		.button_need      (button_need),
		.long_press_mode  (long_press_mode),
		.supply_low_detect(supply_low_detect),
		.main_supply_fail (main_supply_fail),
		.seal_request     (seal_request),
		.watchdog_fault   (watchdog_fault),
		.watchdog_irq_mode(watchdog_irq_mode),
		.mem_enable_in_n  (mem_enable_in_n),
		.sys_reset_out    (sys_reset_out),
		.mem_enable_out_n (mem_enable_out_n),
		.backup_select    (backup_select),
		.watchdog_irq     (watchdog_irq)
	);

	cpu_partner cpu_u (
		.sys_clk        (sys_clk),
		.rst_n          (sys_reset_out),
		.mem_req        (mem_req),
		.mem_enable_in_n(mem_enable_in_n),
		.reset_count    (resets)
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic check_bit(input logic got, input logic exp, input string m);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// counts cycles until reset lets go and checks the span
	task automatic wait_rel(input int lo, input int hi);
		int n;
		n = 0;
		while (sys_reset_out !== 1'h1 && n <= hi) begin
			@(negedge sys_clk);
			n++;
		end
		check_bit(n >= lo && n <= hi, 1'h1, "reset span");
	endtask

	task automatic summarize();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_power();
		check_bit(sys_reset_out, 1'h0, "no power-up reset");
		cyc(1000);
		check_bit(mem_enable_out_n, 1'h1, "enable leaks in reset");
		wait_rel(H - 1000, H + 2 * TK - 1000);
	endtask

	task automatic t_backup();
		check_bit(backup_select, 1'h0, "sealed battery on");
		main_supply_fail = 1'h0;
		cyc(6);
		main_supply_fail = 1'h1;
		cyc(6);
		check_bit(backup_select, 1'h1, "no battery on fail");
		main_supply_fail = 1'h0;
		cyc(6);
		check_bit(backup_select, 1'h0, "battery kept");
		seal_request = 1'h1;
		cyc(6);
		seal_request = 1'h0;
		main_supply_fail = 1'h1;
		cyc(6);
		check_bit(backup_select, 1'h0, "seal ignored");
		main_supply_fail = 1'h0;
		cyc(6);
		main_supply_fail = 1'h1;
		cyc(6);
		check_bit(backup_select, 1'h1, "seal not cleared");
		main_supply_fail = 1'h0;
	endtask

	task automatic t_gate();
		mem_req = 1'h1;
		cyc(6);
		check_bit(mem_enable_out_n, 1'h0, "enable blocked");
		mem_req = 1'h0;
		cyc(6);
		check_bit(mem_enable_out_n, 1'h1, "enable stuck");
		mem_req = 1'h1;
	endtask

	task automatic t_supply();
		for (int i = 0; i < NUM_SUPPLY; i++) begin
			supply_low_detect = 5'h01 << i;
			cyc(6);
			check_bit(sys_reset_out, 1'h0, "supply low no reset");
			check_bit(mem_enable_out_n, 1'h1, "write not cut");
			cyc(100);
			supply_low_detect = 5'h00;
			cyc(2);
		end
		supply_low_detect = 5'h10;
		cyc(100);
		supply_low_detect = 5'h00;
		wait_rel(H - TK, H + 2 * TK);
	endtask

	task automatic t_manual();
		int r0;
		r0 = resets;
		// bounce pulses stay well under the four-tick debounce
		repeat (3) begin
			manual_reset_in_n = 1'h0;
			cyc(10);
			manual_reset_in_n = 1'h1;
			cyc(10);
		end
		check_bit(sys_reset_out, 1'h1, "bounce reset");
		manual_reset_in_n = 1'h0;
		cyc(200);
		check_bit(sys_reset_out, 1'h0, "manual no reset");
		manual_reset_in_n = 1'h1;
		wait_rel(H - TK, H + 2 * TK);
		check_bit(resets == r0 + 1, 1'h1, "reset count");
	endtask

	task automatic t_long();
		long_press_mode = 1'h1;
		button_n = 2'h2;
		cyc(200);
		check_bit(sys_reset_out, 1'h1, "one of two reset");
		// each press is shorter than eight ticks, together they are not
		button_n = 2'h0;
		cyc(40);
		button_n = 2'h1;
		cyc(20);
		button_n = 2'h0;
		cyc(40);
		check_bit(sys_reset_out, 1'h1, "no restart");
		cyc(100);
		check_bit(sys_reset_out, 1'h0, "long press no reset");
		button_n = 2'h3;
		wait_rel(H - TK, H + 2 * TK);
		long_press_mode = 1'h0;
		button_n = 2'h0;
		cyc(200);
		check_bit(sys_reset_out, 1'h1, "mode off reset");
		button_n = 2'h3;
	endtask

	task automatic t_watchdog();
		int p;
		p = 0;
		// the mode must settle through the filter before the fault edge
		watchdog_irq_mode = 1'h1;
		cyc(6);
		watchdog_fault = 1'h1;
		repeat (10) begin
			@(negedge sys_clk);
			p += (watchdog_irq === 1'h1);
		end
		check_bit(p == 1, 1'h1, "irq pulse");
		check_bit(sys_reset_out, 1'h1, "irq mode reset");
		watchdog_fault = 1'h0;
		watchdog_irq_mode = 1'h0;
		cyc(6);
		watchdog_fault = 1'h1;
		cyc(6);
		check_bit(sys_reset_out, 1'h0, "no reboot");
		watchdog_fault = 1'h0;
		wait_rel(H - 2 * TK, H + 2 * TK);
	endtask

	// ---------------------------------------------------------------
	// run
	// ---------------------------------------------------------------
	initial begin
		// five holds of about 11200 cycles each plus margin
		repeat (80_000) @(posedge sys_clk);
		num_errors++;
		$display("FAIL %0t watchdog expired", $time);
		summarize();
	end

	initial begin
		cyc(5);
		reset = 1'h0;
		t_power();
		t_backup();
		t_gate();
		t_supply();
		t_gate();
		t_manual();
		t_long();
		t_watchdog();
		summarize();
	end
endmodule

// [shared/qual_if.sv]
`timescale 1ns/1ps
interface qual_if;
	logic level;
	logic tick;
	logic held;
	modport owner (output level, output tick, input held);
	modport qual  (input level, input tick, output held);
endinterface

// [shared/sup_pkg.sv]
package sup_pkg;

	// ---------------------------------------------------------------
	// timebase
	// ---------------------------------------------------------------
	localparam int unsigned CLK_HZ      = 125_000_000;
	localparam int unsigned TICK_HZ     = 1_000_000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
	localparam int unsigned US_PER_MS   = 1000;
	localparam int          DIV_W       = 7;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);
	localparam logic [DIV_W-1:0] DIV_RST  = 7'h00;

	// ---------------------------------------------------------------
	// times, in their own units, and tick counts
	// ---------------------------------------------------------------
	localparam int unsigned RESET_HOLD_MS        = 140;
	localparam int unsigned HOLD_MIN_US          = 1400;
	localparam int unsigned HOLD_MAX_MS          = 1680;
	localparam int unsigned DEBOUNCE_MS          = 20;
	localparam int unsigned BUTTON_HOLD_DELAY_MS = 7000;
	// ticks per microsecond first, so the products stay inside 32 bits
	localparam int unsigned RESET_HOLD_TICKS =
		RESET_HOLD_MS * US_PER_MS * (TICK_HZ / 1_000_000);
	localparam int unsigned HOLD_MIN_TICKS   =
		HOLD_MIN_US * (TICK_HZ / 1_000_000);
	localparam int unsigned HOLD_MAX_TICKS   =
		HOLD_MAX_MS * US_PER_MS * (TICK_HZ / 1_000_000);
	localparam int unsigned DEBOUNCE_TICKS   =
		DEBOUNCE_MS * US_PER_MS * (TICK_HZ / 1_000_000);
	localparam int unsigned PRESS_TICKS      =
		BUTTON_HOLD_DELAY_MS * US_PER_MS * (TICK_HZ / 1_000_000);
	localparam int          CNT_W   = 24;
	localparam logic [CNT_W-1:0] CNT_RST = 24'h00_0000;

	// ---------------------------------------------------------------
	// pin vector layout
	// ---------------------------------------------------------------
	localparam int NUM_SUPPLY = 5;
	localparam int NUM_BUTTON = 2;
	localparam int PIN_W      = 16;
	localparam int P_MAN      = 0;
	localparam int P_BTN      = 1;
	localparam int P_NEED     = 3;
	localparam int P_LPM      = 5;
	localparam int P_LOW      = 6;
	localparam int P_MAIN     = 11;
	localparam int P_SEAL     = 12;
	localparam int P_WDF      = 13;
	localparam int P_WDM      = 14;
	localparam int P_CE       = 15;
	// active-low pins idle high, main supply counts as failed until seen
	localparam logic [PIN_W-1:0] PIN_RST = 16'h8807;

	typedef enum logic {
		ph_hold = 1'b0,
		ph_run  = 1'b1
	} phase_t;

	// keeps a requested pulse width inside the supported range
	function automatic int unsigned hold_limit(input int unsigned t);
		if (t < HOLD_MIN_TICKS)
			return HOLD_MIN_TICKS;
		if (t > HOLD_MAX_TICKS)
			return HOLD_MAX_TICKS;
		return t;
	endfunction

endpackage

// [verilog/hold_qualifier.sv]
`timescale 1ns/1ps
module hold_qualifier
	import sup_pkg::*;
#(
	parameter int unsigned TICKS = DEBOUNCE_TICKS
) (
	input wire logic sys_clk,
	input wire logic reset,
	qual_if.qual     q
);

	localparam logic [CNT_W-1:0] LAST = CNT_W'(TICKS - 1);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             held;
	} qstate_t;

	qstate_t r_q;
	qstate_t r_d;

	// any drop of the level restarts qualification, so bounce never
	// produces more than one rising edge on held
	always_comb begin
		r_d = r_q;
		if (!q.level) begin
			r_d.cnt  = CNT_RST;
			r_d.held = 1'b0;
		end else if (q.tick && !r_q.held) begin
			if (r_q.cnt == LAST) begin
				r_d.held = 1'b1;
			end else begin
				r_d.cnt = r_q.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign q.held = r_q.held;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	qual_time_a: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(r_q.held) |-> $past(r_q.cnt) == LAST && $past(q.tick))
		else $error("qualified before the full hold count");
	qual_drop_a: assert property (@(posedge sys_clk) disable iff (reset)
		!q.level |=> !r_q.held && r_q.cnt == CNT_RST)
		else $error("release did not restart qualification");

endmodule

// [verilog/supervisor_reset_sequencer.sv]
// Function
// - after power-up the reset output is asserted and held for one pulse width.
// - a supply-low indication holds reset and one full pulse width after it clears.
// - an active manual reset input asserts reset for at least one pulse width.
// - the manual reset input is debounced inside so one press gives one request.
// - the pulse width is a parameter clamped to 1.4 ms through 1680 ms.
// - in long-press mode short closures are ignored and only a long hold resets.
// - supply-low detection has no disable of any kind and is always active.
// - reset is active low by default and a build parameter makes it active high.
// - the memory enable is blocked as soon as a falling supply is seen.
// - a watchdog failure either reboots through reset or raises an interrupt.
// - any of five supply-low indications asserts the common reset.
// - a failed main supply selects the backup battery source.
// - all selected buttons must be held together; releasing any restarts the delay.
// - the memory enable passes while reset is off and is held inactive in reset.
// - an engaged battery seal keeps the battery off until the supply is next good.
`timescale 1ns/1ps
module supervisor_reset_sequencer
	import sup_pkg::*;
#(
	parameter int unsigned HOLD_TICKS       = RESET_HOLD_TICKS,
	parameter int unsigned DEB_TICKS        = DEBOUNCE_TICKS,
	parameter int unsigned HOLD_PRESS_TICKS = PRESS_TICKS,
	parameter int unsigned TICK_LEN         = TICK_CYCLES,
	parameter bit          RESET_ACT_HIGH   = 1'b0
) (
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	input  wire logic                  manual_reset_in_n,
	input  wire logic [NUM_BUTTON-1:0] button_n,
	input  wire logic [NUM_BUTTON-1:0] button_need,
	input  wire logic                  long_press_mode,
	input  wire logic [NUM_SUPPLY-1:0] supply_low_detect,
	input  wire logic                  main_supply_fail,
	input  wire logic                  seal_request,
	input  wire logic                  watchdog_fault,
	input  wire logic                  watchdog_irq_mode,
	input  wire logic                  mem_enable_in_n,
	output logic                       sys_reset_out,
	output logic                       mem_enable_out_n,
	output logic                       backup_select,
	output logic                       watchdog_irq
);

	localparam logic [CNT_W-1:0] HOLD_LAST =
		CNT_W'(hold_limit(HOLD_TICKS) - 1);
	localparam logic RST_ON  = RESET_ACT_HIGH;
	localparam logic RST_OFF = ~RESET_ACT_HIGH;
	// clock cycles per timebase tick, minus one
	localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(TICK_LEN - 1);

	typedef struct packed {
		logic [PIN_W-1:0] s1;
		logic [PIN_W-1:0] s2;
		logic [PIN_W-1:0] s3;
		logic [PIN_W-1:0] f;
		logic [DIV_W-1:0] div;
		logic             tick;
		phase_t           ph;
		logic [CNT_W-1:0] cnt;
		logic             man_prev;
		logic             lp_prev;
		logic             seal;
		logic             rst_out;
		logic             ce_out_n;
		logic             backup;
		logic             irq;
	} top_t;

	top_t r_q;
	top_t r_d;

	// ---------------------------------------------------------------
	// qualifiers
	// ---------------------------------------------------------------
	qual_if man_if ();
	qual_if lp_if ();

	logic [PIN_W-1:0]      pins;
	logic [NUM_BUTTON-1:0] need;
	logic [NUM_BUTTON-1:0] pressed;
	logic                  low_any;
	logic                  wd_rise;
	logic                  man_new;
	logic                  lp_new;
	logic                  req;
	logic [PIN_W-1:0]      f_nx;

	assign pins = {mem_enable_in_n, watchdog_irq_mode, watchdog_fault,
		seal_request, main_supply_fail, supply_low_detect,
		long_press_mode, button_need, button_n, manual_reset_in_n};

	assign need    = r_q.f[P_NEED +: NUM_BUTTON];
	assign pressed = ~r_q.f[P_BTN +: NUM_BUTTON];

	assign man_if.level = ~r_q.f[P_MAN];
	assign man_if.tick  = r_q.tick;
	// every selected button at once, and at least one selected
	assign lp_if.level  = r_q.f[P_LPM] && (need != '0) &&
		((pressed & need) == need);
	assign lp_if.tick   = r_q.tick;

	hold_qualifier #(
		.TICKS (DEB_TICKS)
	) u_man (
		.sys_clk (sys_clk),
		.reset   (reset),
		.q       (man_if.qual)
	);

	hold_qualifier #(
		.TICKS (HOLD_PRESS_TICKS)
	) u_lp (
		.sys_clk (sys_clk),
		.reset   (reset),
		.q       (lp_if.qual)
	);

	// ---------------------------------------------------------------
	// request merge
	// ---------------------------------------------------------------
	// no enable term exists on this path on purpose
	assign low_any = |r_q.f[P_LOW +: NUM_SUPPLY];
	// a bit changes only once the second and third stages agree
	assign f_nx    = (r_q.s2 & ~(r_q.s2 ^ r_q.s3)) |
		(r_q.f & (r_q.s2 ^ r_q.s3));
	assign wd_rise = f_nx[P_WDF] && !r_q.f[P_WDF];
	assign man_new = man_if.held && !r_q.man_prev;
	assign lp_new  = lp_if.held && !r_q.lp_prev;
	// manual and long-press requests stretch reset while still held
	assign req = low_any || man_if.held || lp_if.held ||
		(wd_rise && !r_q.f[P_WDM]);

	always_comb begin
		r_d          = r_q;
		r_d.s1       = pins;
		r_d.s2       = r_q.s1;
		r_d.s3       = r_q.s2;
		r_d.f        = f_nx;
		r_d.man_prev = man_if.held;
		r_d.lp_prev  = lp_if.held;
		r_d.tick     = 1'b0;
		if (r_q.div == TICK_LAST) begin
			r_d.div  = DIV_RST;
			r_d.tick = 1'b1;
		end else begin
			r_d.div  = r_q.div + 1'b1;
		end

		unique case (r_q.ph)
			ph_hold: begin
				if (req) begin
					r_d.cnt = CNT_RST;
				end else if (r_q.tick) begin
					if (r_q.cnt == HOLD_LAST) begin
						r_d.ph  = ph_run;
						r_d.cnt = CNT_RST;
					end else begin
						r_d.cnt = r_q.cnt + 1'b1;
					end
				end
			end
			ph_run: begin
				if (req) begin
					r_d.ph  = ph_hold;
					r_d.cnt = CNT_RST;
				end
			end
		endcase

		// the set wins over the clear when both land in one cycle
		if (r_d.f[P_SEAL] && !r_q.f[P_SEAL]) begin
			r_d.seal = 1'b1;
		end else if (r_q.f[P_MAIN] && !r_d.f[P_MAIN]) begin
			r_d.seal = 1'b0;
		end

		r_d.rst_out  = (r_d.ph == ph_hold) ? RST_ON : RST_OFF;
		// cuts on the filtered supply flag too, one cycle ahead of the phase
		r_d.ce_out_n = r_d.f[P_CE] || (r_d.ph == ph_hold) ||
			(|r_d.f[P_LOW +: NUM_SUPPLY]);
		r_d.backup   = r_d.f[P_MAIN] && !r_d.seal;
		r_d.irq      = wd_rise && r_q.f[P_WDM];
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			r_q          <= '0;
			r_q.s1       <= PIN_RST;
			r_q.s2       <= PIN_RST;
			r_q.s3       <= PIN_RST;
			r_q.f        <= PIN_RST;
			r_q.ph       <= ph_hold;
			r_q.seal     <= 1'b1;
			r_q.rst_out  <= RST_ON;
			r_q.ce_out_n <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	assign sys_reset_out    = r_q.rst_out;
	assign mem_enable_out_n = r_q.ce_out_n;
	assign backup_select    = r_q.backup;
	assign watchdog_irq     = r_q.irq;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	// the output register follows the phase in the same edge
	out_level_a: assert property (
		r_q.ph == ph_hold |-> sys_reset_out == RST_ON)
		else $error("reset output not asserted while holding");
	low_restart_a: assert property (
		low_any |=> r_q.ph == ph_hold && r_q.cnt == CNT_RST)
		else $error("supply-low did not restart the hold");
	full_width_a: assert property (
		$rose(r_q.ph == ph_run) |-> $past(r_q.cnt) == HOLD_LAST)
		else $error("reset released before the full width");
	release_a: assert property (
		r_q.ph == ph_hold && r_q.tick && r_q.cnt == HOLD_LAST && !req
		|=> r_q.ph == ph_run)
		else $error("reset not released at the end of the width");
	manual_a: assert property (
		man_new |=> r_q.ph == ph_hold ##1 sys_reset_out == RST_ON)
		else $error("manual request did not assert reset");
	long_a: assert property (
		lp_new |=> r_q.ph == ph_hold)
		else $error("long press did not assert reset");
	ce_block_a: assert property (
		r_q.ph == ph_hold || low_any |-> mem_enable_out_n)
		else $error("memory enable passed during reset");
	ce_pass_a: assert property (
		r_q.ph == ph_run && !req && !r_d.f[P_CE] &&
		!(|r_d.f[P_LOW +: NUM_SUPPLY]) |=> !mem_enable_out_n)
		else $error("memory enable not passed in normal run");
	backup_a: assert property (
		r_d.f[P_MAIN] && !r_d.seal |=> backup_select)
		else $error("backup source not selected on main fail");
	seal_a: assert property (
		r_q.seal && r_q.f[P_MAIN] && r_d.f[P_MAIN] |=> !backup_select)
		else $error("sealed battery was connected");
	wdog_a: assert property (
		wd_rise |=> (r_q.f[P_WDM] ? watchdog_irq : r_q.ph == ph_hold))
		else $error("watchdog failure had no response");

	por_c:   cover property ($rose(r_q.ph == ph_run));
	man_c:   cover property (man_new);
	long_c:  cover property (lp_new);
	wdirq_c: cover property (watchdog_irq);

endmodule
